// ===== include/snc_pkg.sv
package snc_pkg;

  // ***************************************************************
  // Register numbers (printed offsets, used directly as addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_IDENT    = 8'h00;
  localparam logic [7:0] ADDR_DESCR    = 8'h01;
  localparam logic [7:0] ADDR_LOCKHDR  = 8'h04;
  localparam logic [7:0] ADDR_NODE_ID  = 8'h05;
  localparam logic [7:0] ADDR_PLL      = 8'h06;
  localparam logic [7:0] ADDR_SW_DIV   = 8'h07;
  localparam logic [7:0] ADDR_REF_DIV  = 8'h08;
  localparam logic [7:0] ADDR_DIR_LO   = 8'h0C;
  localparam logic [7:0] ADDR_DIR_HI   = 8'h0D;
  localparam logic [7:0] ADDR_DBG_CFG  = 8'h10;
  localparam logic [7:0] ADDR_DBG_SRC  = 8'h1F;
  localparam logic [7:0] ADDR_LNK_ST   = 8'h20;
  localparam logic [7:0] ADDR_PLNK_ST  = 8'h40;
  localparam logic [7:0] ADDR_LNK_CFG  = 8'h80;
  localparam logic [7:0] ADDR_LNK_STAT = 8'hA0;
  localparam logic [7:0] LNK_SPAN      = 8'h07;
  localparam logic [7:0] PLNK_SPAN     = 8'h03;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int GLOCK_BIT = 31;
  localparam int PLOCK_BIT = 8;
  localparam int HDR_BIT   = 0;
  localparam int OD_MSB    = 25;
  localparam int OD_LSB    = 23;
  localparam int FB_MSB    = 20;
  localparam int FB_LSB    = 8;
  localparam int IDIV_MSB  = 6;
  localparam int IDIV_LSB  = 0;
  localparam int ID_CHIP_LSB = 24;
  localparam int ID_MODE_LSB = 16;
  localparam int ID_REV_LSB  = 8;
  localparam int DIR_W       = 4;
  localparam int NID_W       = 16;

  // ***************************************************************
  // Reset values and identity (identity values are arbitrary)
  // ***************************************************************
  localparam logic [15:0] NODE_ID_RST = 16'h0000;
  localparam logic [15:0] SW_DIV_RST  = 16'h0000;
  localparam logic [15:0] REF_DIV_RST = 16'h0003;
  localparam logic [31:0] DIR_RST     = 32'h0000_0000;
  localparam logic [7:0]  CHIP_ID     = 8'h5A;  // Arbitrary value
  localparam logic [7:0]  SW_REVISION = 8'h01;  // Arbitrary value
  localparam logic [7:0]  SW_VERSION  = 8'h02;  // Arbitrary value
  localparam logic [7:0]  NUM_LINKS   = 8'h08;
  localparam logic [7:0]  NUM_CORES   = 8'h01;
  localparam logic [7:0]  LINKS_PER_CORE = 8'h04;

  // Boot PLL factors {od[2:0], fb[12:0], idiv[6:0]} per boot-pin code
  localparam logic [3:0][22:0] PLL_BOOT = {
    23'h0_0C_01, 23'h0_0A_01, 23'h1_08_01, 23'h0_04_00
  };

endpackage : snc_pkg

// ===== core/snc_regs.sv
module snc_regs
  import snc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        boot_select_pin_a,
  input  wire logic        boot_select_pin_b,
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic             cfg_err,
  output logic [31:0]      cfg_rdata,
  input  wire logic        rt_req,
  input  wire logic [15:0] rt_dest,
  output logic             rt_valid,
  output logic             rt_local,
  output logic [3:0]       rt_dir,
  output logic             header_one_byte,
  output logic             tile_reset,
  output logic [2:0]       pll_output_divider,
  output logic [12:0]      pll_feedback_mult,
  output logic [6:0]       pll_input_divider,
  output logic [15:0]      switch_clk_div,
  output logic [15:0]      ref_clk_div
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic        boot_done;
    logic [1:0]  mode;
    logic        glock;
    logic        plock;
    logic        hdr;
    logic [15:0] node_id;
    logic [2:0]  od;
    logic [12:0] fb;
    logic [6:0]  idiv;
    logic [15:0] sw_div;
    logic [15:0] rf_div;
    logic [31:0] dir_lo;
    logic [31:0] dir_hi;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        tile_rst;
    logic        rt_valid;
    logic        rt_local;
    logic [3:0]  rt_dir;
  } snc_state_s;

  snc_state_s st_q;
  snc_state_s st_d;

  // ***************************************************************
  // Route table lookup
  // ***************************************************************
  logic [15:0] mismatch;
  logic [3:0]  dir_of [16];
  logic [31:0] dir_all_w;

  // Mismatch per bit and its table entry, one slice per id bit
  assign dir_all_w = st_q.dir_lo;
  genvar gi;
  generate
    for (gi = 0; gi < NID_W; gi++) begin : g_bit
      assign mismatch[gi] = rt_dest[gi] ^ st_q.node_id[gi];
      if (gi < 8) begin : g_lo
        assign dir_of[gi] = dir_all_w[gi*DIR_W +: DIR_W];
      end else begin : g_hi
        assign dir_of[gi] = st_q.dir_hi[(gi-8)*DIR_W +: DIR_W];
      end
    end
  endgenerate

  // Highest mismatching bit wins; ascending scan lets later bits override
  logic [3:0] pick_dir;
  always_comb begin
    pick_dir = 4'h0;
    for (int i = 0; i < NID_W; i++) begin
      if (mismatch[i]) begin
        pick_dir = dir_of[i];
      end
    end
  end

  // ***************************************************************
  // Access decode
  // ***************************************************************
  logic wr;
  logic rd;
  logic wr_ok;
  logic pll_wr_ok;
  logic known;
  logic [31:0] rd_val;

  assign wr = cfg_req & cfg_we;
  assign rd = cfg_req & ~cfg_we;
  // Global lock freezes everything including itself until reset
  assign wr_ok = wr & ~st_q.glock;
  assign pll_wr_ok = wr_ok & ~st_q.plock & (cfg_addr == ADDR_PLL);

  // Read mux; link and debug windows belong to other blocks, read zero
  always_comb begin
    known  = 1'b1;
    rd_val = 32'h0000_0000;
    if (cfg_addr == ADDR_IDENT) begin
      rd_val = {CHIP_ID, 6'h00, st_q.mode,
                SW_REVISION, SW_VERSION};
    end else if (cfg_addr == ADDR_DESCR) begin
      rd_val = {8'h00, NUM_LINKS, NUM_CORES, LINKS_PER_CORE};
    end else if (cfg_addr == ADDR_LOCKHDR) begin
      rd_val[GLOCK_BIT] = st_q.glock;
      rd_val[PLOCK_BIT] = st_q.plock;
      rd_val[HDR_BIT]   = st_q.hdr;
    end else if (cfg_addr == ADDR_NODE_ID) begin
      rd_val = {16'h0000, st_q.node_id};
    end else if (cfg_addr == ADDR_PLL) begin
      rd_val[OD_MSB:OD_LSB]     = st_q.od;
      rd_val[FB_MSB:FB_LSB]     = st_q.fb;
      rd_val[IDIV_MSB:IDIV_LSB] = st_q.idiv;
    end else if (cfg_addr == ADDR_SW_DIV) begin
      rd_val = {16'h0000, st_q.sw_div};
    end else if (cfg_addr == ADDR_REF_DIV) begin
      rd_val = {16'h0000, st_q.rf_div};
    end else if (cfg_addr == ADDR_DIR_LO) begin
      rd_val = st_q.dir_lo;
    end else if (cfg_addr == ADDR_DIR_HI) begin
      rd_val = st_q.dir_hi;
    end else if (cfg_addr == ADDR_DBG_CFG || cfg_addr == ADDR_DBG_SRC) begin
      rd_val = 32'h0000_0000;
    end else if (cfg_addr >= ADDR_LNK_ST &&
                 cfg_addr <= ADDR_LNK_ST + LNK_SPAN) begin
      rd_val = 32'h0000_0000;
    end else if (cfg_addr >= ADDR_PLNK_ST &&
                 cfg_addr <= ADDR_PLNK_ST + PLNK_SPAN) begin
      rd_val = 32'h0000_0000;
    end else if (cfg_addr >= ADDR_LNK_CFG &&
                 cfg_addr <= ADDR_LNK_CFG + LNK_SPAN) begin
      rd_val = 32'h0000_0000;
    end else if (cfg_addr >= ADDR_LNK_STAT &&
                 cfg_addr <= ADDR_LNK_STAT + LNK_SPAN) begin
      rd_val = 32'h0000_0000;
    end else begin
      known = 1'b0;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_d          = st_q;
    st_d.tile_rst = 1'b0;
    // Answer one cycle after each configuration access
    st_d.ack   = cfg_req;
    st_d.err   = cfg_req & (~known | (wr & st_q.glock) |
                 (wr & st_q.plock & (cfg_addr == ADDR_PLL)));
    st_d.rdata = rd ? rd_val : 32'h0000_0000;

    // Boot pins caught on the first edge after reset release
    if (!st_q.boot_done) begin
      st_d.boot_done = 1'b1;
      st_d.mode = {boot_select_pin_b, boot_select_pin_a};
      {st_d.od, st_d.fb, st_d.idiv} =
        PLL_BOOT[{boot_select_pin_b, boot_select_pin_a}];
    end

    if (wr_ok) begin
      if (cfg_addr == ADDR_LOCKHDR) begin
        st_d.glock = cfg_wdata[GLOCK_BIT];
        st_d.plock = cfg_wdata[PLOCK_BIT];
        st_d.hdr   = cfg_wdata[HDR_BIT];
      end else if (cfg_addr == ADDR_NODE_ID) begin
        st_d.node_id = cfg_wdata[15:0];
      end else if (cfg_addr == ADDR_SW_DIV) begin
        st_d.sw_div = cfg_wdata[15:0];
      end else if (cfg_addr == ADDR_REF_DIV) begin
        st_d.rf_div = cfg_wdata[15:0];
      end else if (cfg_addr == ADDR_DIR_LO) begin
        st_d.dir_lo = cfg_wdata;
      end else if (cfg_addr == ADDR_DIR_HI) begin
        st_d.dir_hi = cfg_wdata;
      end
    end

    // PLL write takes fields and kicks the tile reset pulse
    if (pll_wr_ok) begin
      st_d.od       = cfg_wdata[OD_MSB:OD_LSB];
      st_d.fb       = cfg_wdata[FB_MSB:FB_LSB];
      st_d.idiv     = cfg_wdata[IDIV_MSB:IDIV_LSB];
      st_d.tile_rst = 1'b1;
    end

    // Route answer, local delivery on a full sixteen-bit match
    st_d.rt_valid = rt_req;
    st_d.rt_local = rt_req & (mismatch == 16'h0000);
    st_d.rt_dir   = (rt_req && mismatch != 16'h0000) ? pick_dir : 4'h0;
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q           <= '0;
      st_q.node_id   <= NODE_ID_RST;
      st_q.sw_div    <= SW_DIV_RST;
      st_q.rf_div    <= REF_DIV_RST;
      st_q.dir_lo    <= DIR_RST;
      st_q.dir_hi    <= DIR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops; dividers feed clock gen
  assign cfg_ack            = st_q.ack;
  assign cfg_err            = st_q.err;
  assign cfg_rdata          = st_q.rdata;
  assign rt_valid           = st_q.rt_valid;
  assign rt_local           = st_q.rt_local;
  assign rt_dir             = st_q.rt_dir;
  assign header_one_byte    = st_q.hdr;
  assign tile_reset         = st_q.tile_rst;
  assign pll_output_divider = st_q.od;
  assign pll_feedback_mult  = st_q.fb;
  assign pll_input_divider  = st_q.idiv;
  assign switch_clk_div     = st_q.sw_div;
  assign ref_clk_div        = st_q.rf_div;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence pll_write_taken;
    wr && !st_q.glock && !st_q.plock && cfg_addr == ADDR_PLL;
  endsequence

  sequence tile_pulse;
    tile_reset ##1 !tile_reset;
  endsequence

  global_lock_a: assert property (
    wr && st_q.glock |=> $stable(st_q.node_id) && $stable(st_q.dir_lo)
                         && cfg_err)
    else $error("write accepted under global lock");

  pll_lock_a: assert property (
    wr && st_q.plock && cfg_addr == ADDR_PLL
      |=> $stable(st_q.fb) && !tile_reset)
    else $error("PLL write accepted under PLL lock");

  // A second PLL write right behind stretches the pulse, so skip that case
  tile_reset_a: assert property (
    pll_write_taken ##1 !(wr && cfg_addr == ADDR_PLL) |-> tile_pulse)
    else $error("tile reset pulse missing after PLL write");

  header_mode_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_LOCKHDR
      |=> header_one_byte == $past(cfg_wdata[HDR_BIT]))
    else $error("header mode not taken from write");

  node_id_read_a: assert property (
    rd && cfg_addr == ADDR_NODE_ID
      |=> cfg_ack && cfg_rdata == {16'h0000, $past(st_q.node_id)})
    else $error("node id read wrong");

  route_local_a: assert property (
    rt_req && rt_dest == st_q.node_id |=> rt_valid && rt_local)
    else $error("matching destination not delivered locally");

  route_top_a: assert property (
    rt_req && (rt_dest[15] != st_q.node_id[15])
      |=> !rt_local && rt_dir == $past(st_q.dir_hi[31:28]))
    else $error("top bit mismatch picked wrong direction");

  route_bottom_a: assert property (
    rt_req && rt_dest[15:1] == st_q.node_id[15:1]
      && rt_dest[0] != st_q.node_id[0]
      |=> rt_dir == $past(st_q.dir_lo[3:0]))
    else $error("bit zero mismatch picked wrong direction");

  ident_read_a: assert property (
    rd && cfg_addr == ADDR_IDENT && st_q.boot_done
      |=> cfg_rdata[23:16] == {6'h00, $past(st_q.mode)}
          && cfg_rdata[31:24] == CHIP_ID)
    else $error("identification read wrong");

  // Every access is answered on the very next edge, never unasked
  ack_next_a: assert property (
    cfg_req |=> cfg_ack)
    else $error("access not answered on next edge");

  ack_spurious_a: assert property (
    !cfg_req |=> !cfg_ack)
    else $error("answer without an access");

  // Global lock can only be lifted by a reset
  lock_sticky_a: assert property (
    st_q.glock |=> st_q.glock)
    else $error("global lock cleared without reset");

  // Boot capture loads the pin-selected PLL row unless a write wins
  boot_pll_a: assert property (
    !st_q.boot_done && !(wr && cfg_addr == ADDR_PLL)
      |=> {pll_output_divider, pll_feedback_mult, pll_input_divider}
          == PLL_BOOT[$past({boot_select_pin_b, boot_select_pin_a})])
    else $error("PLL boot factors wrong");

  pll_fields_a: assert property (
    pll_write_taken
      |=> pll_output_divider == $past(cfg_wdata[OD_MSB:OD_LSB])
          && pll_feedback_mult == $past(cfg_wdata[FB_MSB:FB_LSB])
          && pll_input_divider == $past(cfg_wdata[IDIV_MSB:IDIV_LSB]))
    else $error("PLL fields not taken from write");

  // Writable fields take the low bits of an accepted write; direction tables take the whole word
  node_id_write_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_NODE_ID
      |=> st_q.node_id == $past(cfg_wdata[15:0]))
    else $error("node id write lost");

  sw_div_write_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_SW_DIV
      |=> switch_clk_div == $past(cfg_wdata[15:0]))
    else $error("switch divider write lost");

  ref_div_write_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_REF_DIV
      |=> ref_clk_div == $past(cfg_wdata[15:0]))
    else $error("reference divider write lost");

  dir_low_write_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_DIR_LO
      |=> st_q.dir_lo == $past(cfg_wdata))
    else $error("low direction table write lost");

  dir_high_write_a: assert property (
    wr && !st_q.glock && cfg_addr == ADDR_DIR_HI
      |=> st_q.dir_hi == $past(cfg_wdata))
    else $error("high direction table write lost");

  // Read-only words carry the fixed identity and counts
  descr_read_a: assert property (
    rd && cfg_addr == ADDR_DESCR
      |=> cfg_rdata == {8'h00, NUM_LINKS, NUM_CORES, LINKS_PER_CORE})
    else $error("description read wrong");

  ident_fixed_a: assert property (
    rd && cfg_addr == ADDR_IDENT
      |=> cfg_rdata[15:0] == {SW_REVISION, SW_VERSION})
    else $error("revision or version read wrong");

  // Every lookup is answered next edge; local answers carry no direction
  route_answer_a: assert property (
    rt_req |=> rt_valid)
    else $error("lookup not answered");

  local_dir_zero_a: assert property (
    rt_local |-> rt_valid && rt_dir == 4'h0)
    else $error("local delivery with a direction");

endmodule : snc_regs

// ===== bench/snc_cfg_master.sv
// ***************************************************************
// Configuration access issuer standing in for cores and remote nodes
// ***************************************************************
module snc_cfg_master (
  input  wire logic        ref_clk,
  output logic             cfg_req,
  output logic             cfg_we,
  output logic [7:0]       cfg_addr,
  output logic [31:0]      cfg_wdata,
  input  wire logic        cfg_ack,
  input  wire logic        cfg_err,
  input  wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_wdata = 32'h0000_0000;
  end

  // One access: pulse, release, then take the answer on the acked edge
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
    int n;
    n = 0;
    // Random idle gap so requests arrive both promptly and slowly
    repeat ($urandom_range(2)) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    cfg_req   = 1'b1;
    cfg_we    = we;
    cfg_addr  = a;
    cfg_wdata = wd;
    @(posedge ref_clk);
    #1;
    // Released lines show the inverse, not a stale copy
    cfg_req   = 1'b0;
    cfg_we    = ~we;
    cfg_addr  = ~a;
    cfg_wdata = ~wd;
    // Answer stands from the taking edge; anything later is a fault
    while (n < 4 && cfg_ack !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    rd = (n == 0) ? cfg_rdata : 'x;
    er = (n == 0) ? cfg_err : 1'bx;
  endtask : xfer
endmodule : snc_cfg_master

// ===== bench/tb_top.sv
module tb_top
  import snc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, arst_n, pin_a, pin_b, cfg_req, cfg_we, cfg_ack;
  logic        cfg_err, rt_req, rt_valid, rt_local, hdr, tile_rst, er;
  logic [7:0]  cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, rdv, lo, hi, pll;
  logic [15:0] rt_dest, sw_div, ref_div, nid, sw;
  logic [3:0]  rt_dir;
  logic [2:0]  od;
  logic [12:0] fb;
  logic [6:0]  idv;
  int          n_errors, n_checks, n_tr, t;

  snc_regs dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
    .boot_select_pin_a(pin_a), .boot_select_pin_b(pin_b),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_err(cfg_err),
    .cfg_rdata(cfg_rdata), .rt_req(rt_req), .rt_dest(rt_dest),
    .rt_valid(rt_valid), .rt_local(rt_local), .rt_dir(rt_dir),
    .header_one_byte(hdr), .tile_reset(tile_rst),
    .pll_output_divider(od), .pll_feedback_mult(fb),
    .pll_input_divider(idv), .switch_clk_div(sw_div),
    .ref_clk_div(ref_div));

  snc_cfg_master m_u (.ref_clk(ref_clk), .cfg_req(cfg_req),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_err(cfg_err), .cfg_rdata(cfg_rdata));

  // ***************************************************************
  // Clock, tile reset pulse counter, watchdog
  // ***************************************************************
  always #5 ref_clk = ~ref_clk;

  // Counted mid-cycle, where the pulse has settled
  always @(negedge ref_clk) begin
    if (tile_rst === 1'b1) n_tr++;
  end

  // Whole run is a few hundred cycles; 10000 means a hang
  initial begin
    #100000;
    n_errors++;
    results();
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic rd(input logic [7:0] a);
    m_u.xfer(1'b0, a, 32'h0000_0000, rdv, er);
    if (er === 1'bx) begin
      n_errors++;
      results();
    end
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    m_u.xfer(1'b1, a, d, rdv, er);
    if (er === 1'bx) begin
      n_errors++;
      results();
    end
  endtask : wr

  // Expected {valid, local, dir}: highest differing bit picks a nibble
  function automatic logic [5:0] route(input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      if (d[i] != nid[i])
        return {2'b10, (i > 7) ? hi[4*(i-8) +: 4] : lo[4*i +: 4]};
    end
    return 6'h30;
  endfunction : route

  task automatic results();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    ref_clk = 1'b0;
    arst_n  = 1'b0;
    rt_req  = 1'b0;
    rt_dest = 16'h0000;
    void'($urandom(61103));
    {pin_b, pin_a} = 2'($urandom);
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    pll = {6'h00, PLL_BOOT[{pin_b, pin_a}][22:20], 2'b00,
           PLL_BOOT[{pin_b, pin_a}][19:7], 1'b0,
           PLL_BOOT[{pin_b, pin_a}][6:0]};
    // Reset values and read-only identity
    rd(ADDR_IDENT); chk(rdv, {CHIP_ID, 6'h00, pin_b, pin_a,
                              SW_REVISION, SW_VERSION});
    rd(ADDR_DESCR); chk(rdv, {8'h00, NUM_LINKS, NUM_CORES,
                              LINKS_PER_CORE});
    rd(ADDR_PLL); chk(rdv, pll);
    rd(ADDR_REF_DIV); chk(rdv, 32'h0000_0003);
    chk(32'(ref_div), 32'h0000_0003);
    rd(ADDR_SW_DIV); chk(rdv, 32'h0000_0000);
    rd(ADDR_NODE_ID); chk(rdv, 32'h0000_0000);
    rd(ADDR_DIR_LO); chk(rdv, 32'h0000_0000);
    rd(ADDR_DIR_HI); chk(rdv, 32'h0000_0000);
    wr(ADDR_IDENT, 32'hFFFF_FFFF);
    rd(ADDR_IDENT); chk(rdv[31:24], CHIP_ID);
    // Node id with reserved half set, then both direction tables
    nid = 16'($urandom);
    lo  = $urandom;
    hi  = $urandom;
    wr(ADDR_NODE_ID, {16'hFFFF, nid});
    rd(ADDR_NODE_ID); chk(rdv, {16'h0000, nid});
    wr(ADDR_DIR_LO, lo);
    wr(ADDR_DIR_HI, hi);
    rd(ADDR_DIR_LO); chk(rdv, lo);
    rd(ADDR_DIR_HI); chk(rdv, hi);
    // Back-to-back lookups: every single-bit mismatch, a match, random
    @(posedge ref_clk);
    #1;
    for (int i = 0; i < 48; i++) begin
      rt_req  = 1'b1;
      rt_dest = (i < 16) ? nid ^ (16'h0001 << i) :
                (i == 16) ? nid : 16'($urandom);
      @(posedge ref_clk);
      #1;
      chk(32'({rt_valid, rt_local, rt_dir}), 32'(route(rt_dest)));
    end
    rt_req = 1'b0;
    // Header mode written once; every node gets the same value
    wr(ADDR_LOCKHDR, 32'h0000_0001); chk(32'(hdr), 32'h1);
    // Accepted PLL write: reserved bits dropped, tile reset once
    t = n_tr;
    wr(ADDR_PLL, 32'hFFFF_FFFF); chk(32'(er), 32'h0);
    rd(ADDR_PLL); chk(rdv, 32'h039F_FF7F);
    chk(32'({od, fb, idv}), 32'h007F_FFFF);
    chk(n_tr, t + 1);
    // PLL lock: PLL refused, other registers still writable
    sw = 16'($urandom);
    wr(ADDR_LOCKHDR, 32'h0000_0101);
    wr(ADDR_PLL, 32'h0000_0000); chk(32'(er), 32'h1);
    rd(ADDR_PLL); chk(rdv, 32'h039F_FF7F);
    chk(n_tr, t + 1);
    wr(ADDR_SW_DIV, {16'hFFFF, sw}); chk(32'(er), 32'h0);
    rd(ADDR_SW_DIV); chk(rdv, {16'h0000, sw});
    chk(32'(sw_div), 32'(sw));
    // Unmapped address
    rd(8'h02); chk(32'(er), 32'h1);
    chk(rdv, 32'h0000_0000);
    // Global lock refuses every write, including its own clearing
    wr(ADDR_LOCKHDR, 32'h8000_0101);
    wr(ADDR_NODE_ID, {16'h0000, ~nid}); chk(32'(er), 32'h1);
    rd(ADDR_NODE_ID); chk(rdv, {16'h0000, nid});
    wr(ADDR_LOCKHDR, 32'h0000_0000);
    rd(ADDR_LOCKHDR); chk(rdv, 32'h8000_0101);
    // Every boot code through a fresh mid-run reset
    for (int c = 0; c < 4; c++) begin
      @(posedge ref_clk);
      #1;
      arst_n = 1'b0;
      {pin_b, pin_a} = 2'(c);
      repeat (2) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      repeat (2) @(posedge ref_clk);
      rd(ADDR_PLL);
      chk(rdv, {6'h00, PLL_BOOT[c][22:20], 2'b00, PLL_BOOT[c][19:7],
                1'b0, PLL_BOOT[c][6:0]});
      rd(ADDR_IDENT); chk(rdv[23:16], 8'(c));
      rd(ADDR_LOCKHDR); chk(rdv, 32'h0000_0000);
    end
    results();
  end
endmodule : tb_top
